// ===== pkg/csb_pkg.sv
// Constants, opcode patterns and types for the compare, skip and branch unit.
// Assumes a 16-bit instruction word and a word-addressed program counter.
//
// Notes on behaviour
// RQ1: compares take one cycle, set five flags
// RQ2: register bit clear skips next instruction
// RQ3: register bit set skips next instruction
// RQ4: I/O bit clear skips next instruction
// RQ5: I/O bit set skips next instruction
// RQ6: status-bit branches jump PC plus offset plus one
// RQ7: equal/not-equal branch on zero flag
// RQ8: carry-set and lower branch when carry one
// RQ9: carry-clear and same-or-higher when carry zero
// RQ10: minus/plus branch on negative flag
// RQ11: signed branches test negative xor overflow
// RQ12: half-carry branches, flags untouched
// RQ13: discard prefetched words on skip or branch
package csb_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int CSB_PC_W = 16;

	// ----------------------------------------
	// Opcode masks and patterns
	// ----------------------------------------
	localparam logic [15:0] CSB_MASK_CMP = 16'hfc00;
	localparam logic [15:0] CSB_PAT_CMP = 16'h1400;
	localparam logic [15:0] CSB_PAT_CMPC = 16'h0400;
	localparam logic [15:0] CSB_MASK_CMPI = 16'hf000;
	localparam logic [15:0] CSB_PAT_CMPI = 16'h3000;
	localparam logic [15:0] CSB_MASK_SBR = 16'hfe08;
	localparam logic [15:0] CSB_PAT_SKIP_REG_CLEAR = 16'hfc00;
	localparam logic [15:0] CSB_PAT_SKIP_REG_SET = 16'hfe00;
	localparam logic [15:0] CSB_MASK_SBI = 16'hff00;
	localparam logic [15:0] CSB_PAT_SKIP_IO_CLEAR = 16'h9900;
	localparam logic [15:0] CSB_PAT_SKIP_IO_SET = 16'h9b00;
	localparam logic [15:0] CSB_MASK_BR = 16'hfc00;
	localparam logic [15:0] CSB_PAT_BRANCH_SET = 16'hf000;
	localparam logic [15:0] CSB_PAT_BRANCH_CLEAR = 16'hf400;

	// ----------------------------------------
	// Status register bit positions
	// ----------------------------------------
	localparam logic [2:0] CSB_FLAG_C = 3'h0;
	localparam logic [2:0] CSB_FLAG_Z = 3'h1;
	localparam logic [2:0] CSB_FLAG_N = 3'h2;
	localparam logic [2:0] CSB_FLAG_V = 3'h3;
	localparam logic [2:0] CSB_FLAG_S = 3'h4;
	localparam logic [2:0] CSB_FLAG_H = 3'h5;

	// ----------------------------------------
	// Offsets and reset values
	// ----------------------------------------
	localparam logic [15:0] CSB_SKIP_ONE = 16'h0002;
	localparam logic [15:0] CSB_SKIP_TWO = 16'h0003;
	localparam logic [15:0] CSB_BRANCH_BIAS = 16'h0001;
	localparam logic [7:0] CSB_CMP_FLAG_MASK = 8'h2f;
	localparam logic [7:0] CSB_STATUS_RST = 8'h00;
	localparam logic [15:0] CSB_PC_RST = 16'h0000;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0] {
		CSB_OP_NONE, CSB_OP_CMP, CSB_OP_CMPC, CSB_OP_CMPI,
		CSB_OP_SKIP_REG_CLEAR, CSB_OP_SKIP_REG_SET, CSB_OP_SKIP_IO_CLEAR, CSB_OP_SKIP_IO_SET,
		CSB_OP_BRANCH_SET, CSB_OP_BRANCH_CLEAR
	} csb_op_e;

	typedef enum logic [1:0] {CSB_RUN, CSB_HOLD2, CSB_HOLD1} csb_state_e;

endpackage

// ===== hw/csb_unit.sv
// Compare, conditional skip and conditional branch execution unit.
// Assumes register file and I/O bit reads answer in the same cycle
// and that fetch tells whether the following instruction is two words.
`timescale 1ns/1ps
`default_nettype none

module csb_unit
	import csb_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic instr_valid,
	input wire logic [15:0] instr,
	input wire logic [15:0] pc,
	input wire logic next_two_word,
	input wire logic [7:0] rd_value,
	input wire logic [7:0] rr_value,
	input wire logic io_bit,
	input wire logic [7:0] status,
	output logic ready,
	output logic [4:0] rd_index,
	output logic [4:0] rr_index,
	output logic [4:0] io_addr,
	output logic [2:0] io_bit_index,
	output logic status_we,
	output logic [7:0] status_mask,
	output logic [7:0] status_next,
	output logic pc_load,
	output logic [15:0] pc_target,
	output logic flush_fetch,
	output logic retire
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic csb_op_e csb_decode(input logic [15:0] w);
		csb_op_e op;
		op = CSB_OP_NONE;
		if ((w & CSB_MASK_CMP) == CSB_PAT_CMP) begin
			op = CSB_OP_CMP;
		end else if ((w & CSB_MASK_CMP) == CSB_PAT_CMPC) begin
			op = CSB_OP_CMPC;
		end else if ((w & CSB_MASK_CMPI) == CSB_PAT_CMPI) begin
			op = CSB_OP_CMPI;
		end else if ((w & CSB_MASK_SBR) == CSB_PAT_SKIP_REG_CLEAR) begin
			op = CSB_OP_SKIP_REG_CLEAR;
		end else if ((w & CSB_MASK_SBR) == CSB_PAT_SKIP_REG_SET) begin
			op = CSB_OP_SKIP_REG_SET;
		end else if ((w & CSB_MASK_SBI) == CSB_PAT_SKIP_IO_CLEAR) begin
			op = CSB_OP_SKIP_IO_CLEAR;
		end else if ((w & CSB_MASK_SBI) == CSB_PAT_SKIP_IO_SET) begin
			op = CSB_OP_SKIP_IO_SET;
		end else if ((w & CSB_MASK_BR) == CSB_PAT_BRANCH_SET) begin
			op = CSB_OP_BRANCH_SET;
		end else if ((w & CSB_MASK_BR) == CSB_PAT_BRANCH_CLEAR) begin
			op = CSB_OP_BRANCH_CLEAR;
		end
		return op;
	endfunction

	csb_state_e state;
	csb_op_e op;
	logic accept;
	logic is_cmp;
	logic is_skip_op;
	logic is_branch;

	assign op = csb_decode(instr);
	assign ready = (state == CSB_RUN);
	assign accept = instr_valid && ready;
	assign is_cmp = (op == CSB_OP_CMP) || (op == CSB_OP_CMPC) || (op == CSB_OP_CMPI);
	assign is_skip_op = (op == CSB_OP_SKIP_REG_CLEAR) || (op == CSB_OP_SKIP_REG_SET)
		|| (op == CSB_OP_SKIP_IO_CLEAR) || (op == CSB_OP_SKIP_IO_SET);
	assign is_branch = (op == CSB_OP_BRANCH_SET) || (op == CSB_OP_BRANCH_CLEAR);

	// Operand selection
	always_comb begin
		rd_index = instr[8:4];
		if (op == CSB_OP_CMPI) begin
			rd_index = {1'b1, instr[7:4]};
		end
	end
	assign rr_index = {instr[9], instr[3:0]};
	assign io_addr = instr[7:3];
	assign io_bit_index = instr[2:0];

	// ----------------------------------------
	// Compare arithmetic
	// ----------------------------------------
	logic [7:0] subtrahend;
	logic borrow_in;
	logic [8:0] diff;
	logic [7:0] res;
	logic [7:0] next_status;

	assign subtrahend = (op == CSB_OP_CMPI) ? {instr[11:8], instr[3:0]} : rr_value; // RQ1
	assign borrow_in = (op == CSB_OP_CMPC) ? status[CSB_FLAG_C] : 1'b0; // RQ1
	assign diff = {1'b0, rd_value} - {1'b0, subtrahend} - {8'h00, borrow_in}; // RQ1
	assign res = diff[7:0];

	always_comb begin
		next_status = status;
		next_status[CSB_FLAG_H] = (~rd_value[3] & subtrahend[3]) | (subtrahend[3] & res[3])
			| (res[3] & ~rd_value[3]); // RQ1
		next_status[CSB_FLAG_V] = (rd_value[7] & ~subtrahend[7] & ~res[7])
			| (~rd_value[7] & subtrahend[7] & res[7]); // RQ1
		next_status[CSB_FLAG_N] = res[7]; // RQ1
		next_status[CSB_FLAG_C] = (~rd_value[7] & subtrahend[7]) | (subtrahend[7] & res[7])
			| (res[7] & ~rd_value[7]); // RQ1
		next_status[CSB_FLAG_Z] = (res == 8'h00); // RQ1
		if (op == CSB_OP_CMPC) begin
			next_status[CSB_FLAG_Z] = (res == 8'h00) && status[CSB_FLAG_Z]; // RQ1
		end
	end

	// ----------------------------------------
	// Skip and branch conditions
	// ----------------------------------------
	logic skip;
	logic flag_bit;
	logic taken;
	logic [15:0] offset;
	logic [15:0] next_target;

	always_comb begin
		unique case (op)
			CSB_OP_SKIP_REG_CLEAR: skip = !rd_value[instr[2:0]]; // RQ2
			CSB_OP_SKIP_REG_SET: skip = rd_value[instr[2:0]]; // RQ3
			CSB_OP_SKIP_IO_CLEAR: skip = !io_bit; // RQ4
			CSB_OP_SKIP_IO_SET: skip = io_bit; // RQ5
			default: skip = 1'b0;
		endcase
	end

	always_comb begin
		unique case (instr[2:0])
			CSB_FLAG_Z: flag_bit = status[CSB_FLAG_Z]; // RQ7
			CSB_FLAG_C: flag_bit = status[CSB_FLAG_C]; // RQ8 RQ9
			CSB_FLAG_N: flag_bit = status[CSB_FLAG_N]; // RQ10
			CSB_FLAG_S: flag_bit = status[CSB_FLAG_N] ^ status[CSB_FLAG_V]; // RQ11
			CSB_FLAG_H: flag_bit = status[CSB_FLAG_H]; // RQ12
			default: flag_bit = status[instr[2:0]]; // RQ6
		endcase
	end

	assign taken = ((op == CSB_OP_BRANCH_SET) && flag_bit) || ((op == CSB_OP_BRANCH_CLEAR) && !flag_bit); // RQ6
	assign offset = {{9{instr[9]}}, instr[9:3]};

	always_comb begin
		next_target = pc + offset + CSB_BRANCH_BIAS; // RQ6
		if (is_skip_op) begin
			next_target = pc + (next_two_word ? CSB_SKIP_TWO : CSB_SKIP_ONE); // RQ2 RQ4
		end
	end

	// ----------------------------------------
	// Cycle sequencing
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state <= CSB_RUN;
		end else begin
			unique case (state)
				CSB_RUN: begin
					if (accept && skip && next_two_word) begin
						state <= CSB_HOLD2; // RQ3 RQ5
					end else if (accept && (skip || taken)) begin
						state <= CSB_HOLD1; // RQ6 RQ13
					end
				end
				CSB_HOLD2: state <= CSB_HOLD1;
				CSB_HOLD1: state <= CSB_RUN;
				default: state <= CSB_RUN;
			endcase
		end
	end

	// ----------------------------------------
	// Flag write-back
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			status_we <= 1'b0;
			status_mask <= 8'h00;
			status_next <= CSB_STATUS_RST;
		end else begin
			status_we <= accept && is_cmp; // RQ1 RQ12
			status_mask <= (accept && is_cmp) ? CSB_CMP_FLAG_MASK : 8'h00;
			status_next <= next_status;
		end
	end

	// ----------------------------------------
	// Program counter redirect
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pc_load <= 1'b0;
			pc_target <= CSB_PC_RST;
			flush_fetch <= 1'b0;
			retire <= 1'b0;
		end else begin
			pc_load <= accept && (skip || taken); // RQ2 RQ6
			pc_target <= next_target;
			flush_fetch <= accept && (skip || taken); // RQ13
			retire <= accept && (op != CSB_OP_NONE);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence one_hold_s;
		!ready ##1 ready;
	endsequence

	sequence two_hold_s;
		!ready [*2] ##1 ready;
	endsequence

	cmp_single_cycle_a: assert property (accept && is_cmp |=> status_we && ready && !pc_load && retire) // RQ1
		else $error("compare did not finish in one cycle");

	cmp_equal_zero_a: assert property (accept && (op == CSB_OP_CMP) && (rd_value == rr_value) // RQ1
		|=> status_next[CSB_FLAG_Z] && !status_next[CSB_FLAG_C])
		else $error("equal compare did not set zero");

	cmpc_zero_keep_a: assert property (accept && (op == CSB_OP_CMPC) && !status[CSB_FLAG_Z] // RQ1
		|=> !status_next[CSB_FLAG_Z])
		else $error("borrow compare set zero from cleared zero");

	cmp_flag_mask_a: assert property (status_we // RQ1
		|-> (status_mask == CSB_CMP_FLAG_MASK) && ((status_next & ~CSB_CMP_FLAG_MASK) == ($past(status) & ~CSB_CMP_FLAG_MASK)))
		else $error("compare wrote wrong flag mask");

	reg_clear_skip_a: assert property (accept && (op == CSB_OP_SKIP_REG_CLEAR) && !rd_value[instr[2:0]] // RQ2
		&& !next_two_word |=> pc_load && (pc_target == $past(pc) + CSB_SKIP_ONE) ##0 one_hold_s)
		else $error("register clear skip wrong");

	reg_clear_stay_a: assert property (accept && (op == CSB_OP_SKIP_REG_CLEAR) && rd_value[instr[2:0]] // RQ2
		|=> !pc_load && ready && !status_we)
		else $error("register clear skip taken with bit set");

	reg_set_skip_a: assert property (accept && (op == CSB_OP_SKIP_REG_SET) && rd_value[instr[2:0]] // RQ3
		&& next_two_word |=> pc_load && (pc_target == $past(pc) + CSB_SKIP_TWO) ##0 two_hold_s)
		else $error("register set skip wrong");

	io_clear_noskip_a: assert property (accept && (op == CSB_OP_SKIP_IO_CLEAR) && io_bit // RQ4
		|=> !pc_load && ready && !status_we)
		else $error("io clear skip taken wrongly");

	io_clear_two_a: assert property (accept && (op == CSB_OP_SKIP_IO_CLEAR) && !io_bit && next_two_word // RQ4
		|=> pc_load && (pc_target == $past(pc) + CSB_SKIP_TWO) ##0 two_hold_s)
		else $error("io clear skip over two words wrong");

	io_set_skip_a: assert property (accept && (op == CSB_OP_SKIP_IO_SET) && io_bit // RQ5
		|=> pc_load && !status_we ##0 (one_hold_s or two_hold_s))
		else $error("io set skip not taken");

	branch_taken_a: assert property (accept && (op == CSB_OP_BRANCH_SET) && status[instr[2:0]] // RQ6
		&& (instr[2:0] != CSB_FLAG_S)
		|=> pc_load && (pc_target == $past(pc) + $past(offset) + CSB_BRANCH_BIAS) ##0 one_hold_s)
		else $error("status branch target or timing wrong");

	equal_not_taken_a: assert property (accept && (op == CSB_OP_BRANCH_SET) && (instr[2:0] == CSB_FLAG_Z) // RQ7
		&& !status[CSB_FLAG_Z] |=> !pc_load && ready)
		else $error("equal branch taken with zero clear");

	carry_set_branch_a: assert property (accept && (op == CSB_OP_BRANCH_SET) && (instr[2:0] == CSB_FLAG_C) // RQ8
		&& status[CSB_FLAG_C] |=> pc_load ##0 one_hold_s)
		else $error("carry set branch not taken");

	carry_clr_branch_a: assert property (accept && (op == CSB_OP_BRANCH_CLEAR) && (instr[2:0] == CSB_FLAG_C) // RQ9
		&& status[CSB_FLAG_C] |=> !pc_load && ready)
		else $error("carry clear branch taken with carry set");

	plus_not_taken_a: assert property (accept && (op == CSB_OP_BRANCH_CLEAR) && (instr[2:0] == CSB_FLAG_N) // RQ10
		&& status[CSB_FLAG_N] |=> !pc_load && ready)
		else $error("plus branch taken with negative set");

	signed_ge_a: assert property (accept && (op == CSB_OP_BRANCH_CLEAR) && (instr[2:0] == CSB_FLAG_S) // RQ11
		&& (status[CSB_FLAG_N] == status[CSB_FLAG_V]) |=> pc_load)
		else $error("signed greater-equal not taken");

	signed_lt_a: assert property (accept && (op == CSB_OP_BRANCH_SET) && (instr[2:0] == CSB_FLAG_S) // RQ11
		&& (status[CSB_FLAG_N] != status[CSB_FLAG_V]) |=> pc_load ##0 one_hold_s)
		else $error("signed less-than not taken");

	branch_no_flags_a: assert property (accept && (is_branch || is_skip_op) |=> !status_we) // RQ12
		else $error("branch or skip wrote flags");

	half_clr_branch_a: assert property (accept && (op == CSB_OP_BRANCH_CLEAR) && (instr[2:0] == CSB_FLAG_H) // RQ12
		&& !status[CSB_FLAG_H] |=> pc_load && (pc_target == $past(pc) + $past(offset) + CSB_BRANCH_BIAS))
		else $error("half-carry clear branch wrong");

	hold_no_retire_a: assert property (pc_load |-> flush_fetch && !ready ##1 !retire) // RQ13
		else $error("instruction retired after redirect");

	hold_refuse_a: assert property (!ready // RQ13
		|=> !status_we && !retire && !pc_load)
		else $error("instruction taken during hold");

endmodule

`default_nettype wire

// ===== test/csb_unit_tb_top.sv
// Self-checking bench for the compare, skip and branch unit.
// Assumes the unit is driven alone; the bench plays fetch, register file and I/O.
`timescale 1ns/1ps
`default_nettype none

module csb_unit_tb_top
	import csb_pkg::*;
;
	typedef struct packed {
		logic [15:0] instr; logic [15:0] pc; logic ntw; logic [7:0] rd; logic [7:0] rr;
		logic io; logic [7:0] st; logic ret; logic ld; logic [15:0] tgt; logic swe;
	} csb_row_s;

	logic clock, rst_b, instr_valid, next_two_word, io_bit;
	logic [15:0] instr, pc;
	logic [7:0] rd_value, rr_value, status;
	logic ready, status_we, pc_load, flush_fetch, retire;
	logic [4:0] rd_index, rr_index, io_addr;
	logic [2:0] io_bit_index;
	logic [7:0] status_mask, status_next;
	logic [15:0] pc_target;
	int miscompares, cmp_count, cnt;
	csb_row_s rows [28];
	csb_row_s r;
	logic [7:0] opnd;

	csb_unit csb_unit_inst (.clock(clock), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr), .pc(pc),
		.next_two_word(next_two_word), .rd_value(rd_value), .rr_value(rr_value), .io_bit(io_bit),
		.status(status), .ready(ready), .rd_index(rd_index), .rr_index(rr_index), .io_addr(io_addr),
		.io_bit_index(io_bit_index), .status_we(status_we), .status_mask(status_mask),
		.status_next(status_next), .pc_load(pc_load), .pc_target(pc_target), .flush_fetch(flush_fetch),
		.retire(retire));

	// ----------------------------------------
	// Clock and helpers
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	function automatic logic [7:0] exp_flags(input logic [7:0] st, input logic [7:0] a, input logic [7:0] b,
		input logic cy, input logic zk);
		logic [7:0] d;
		logic c, h, v;
		d = a - b - {7'h00, cy};
		c = (~a[7] & b[7]) | (b[7] & d[7]) | (d[7] & ~a[7]);
		h = (~a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~a[3]);
		v = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
		exp_flags = (st & 8'hd0) | {2'b00, h, 1'b0, v, d[7], (d == 8'h00) & zk, c};
	endfunction

	task automatic drive(input csb_row_s x);
		instr = x.instr; pc = x.pc; next_two_word = x.ntw; rd_value = x.rd; rr_value = x.rr;
		io_bit = x.io; status = x.st; instr_valid = 1'b1;
	endtask

	task automatic wrap_up();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		#20000;
		miscompares++;
		wrap_up();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rows = '{
			'{16'h1412, 16'h0010, 0, 8'h10, 8'h01, 0, 8'hd0, 1, 0, 16'h0, 1},
			'{16'h0412, 16'h0010, 0, 8'h05, 8'h05, 0, 8'h03, 1, 0, 16'h0, 1},
			'{16'h0412, 16'h0010, 0, 8'h06, 8'h05, 0, 8'h03, 1, 0, 16'h0, 1},
			'{16'h3f5f, 16'h0010, 0, 8'h80, 8'h00, 0, 8'h10, 1, 0, 16'h0, 1},
			'{16'hfc32, 16'h0100, 0, 8'hfb, 8'h00, 0, 8'h3f, 1, 1, 16'h0102, 0},
			'{16'hfc32, 16'h0100, 0, 8'h04, 8'h00, 0, 8'h00, 1, 0, 16'h0, 0},
			'{16'hfe37, 16'h0200, 1, 8'h80, 8'h00, 0, 8'h00, 1, 1, 16'h0203, 0},
			'{16'hfe37, 16'h0200, 1, 8'h7f, 8'h00, 0, 8'h00, 1, 0, 16'h0, 0},
			'{16'h990d, 16'h0300, 0, 8'h00, 8'h00, 0, 8'h00, 1, 1, 16'h0302, 0},
			'{16'h990d, 16'h0300, 0, 8'h00, 8'h00, 1, 8'h00, 1, 0, 16'h0, 0},
			'{16'h9b0d, 16'h0400, 1, 8'h00, 8'h00, 1, 8'h00, 1, 1, 16'h0403, 0},
			'{16'h9b0d, 16'h0400, 1, 8'h00, 8'h00, 0, 8'h00, 1, 0, 16'h0, 0},
			'{16'hf029, 16'h1000, 0, 8'h00, 8'h00, 0, 8'h02, 1, 1, 16'h1006, 0},
			'{16'hf029, 16'h1000, 0, 8'h00, 8'h00, 0, 8'h00, 1, 0, 16'h0, 0},
			'{16'hf7e9, 16'h1000, 0, 8'h00, 8'h00, 0, 8'h00, 1, 1, 16'h0ffe, 0},
			'{16'hf7e9, 16'h1000, 0, 8'h00, 8'h00, 0, 8'h02, 1, 0, 16'h0, 0},
			'{16'hf028, 16'h2000, 0, 8'h00, 8'h00, 0, 8'h01, 1, 1, 16'h2006, 0},
			'{16'hf428, 16'h2000, 0, 8'h00, 8'h00, 0, 8'h01, 1, 0, 16'h0, 0},
			'{16'hf428, 16'h2000, 0, 8'h00, 8'h00, 0, 8'h00, 1, 1, 16'h2006, 0},
			'{16'hf02a, 16'h3000, 0, 8'h00, 8'h00, 0, 8'h04, 1, 1, 16'h3006, 0},
			'{16'hf42a, 16'h3000, 0, 8'h00, 8'h00, 0, 8'h04, 1, 0, 16'h0, 0},
			'{16'hf02c, 16'h4000, 0, 8'h00, 8'h00, 0, 8'h04, 1, 1, 16'h4006, 0},
			'{16'hf42c, 16'h4000, 0, 8'h00, 8'h00, 0, 8'h1c, 1, 1, 16'h4006, 0},
			'{16'hf02c, 16'h4000, 0, 8'h00, 8'h00, 0, 8'h10, 1, 0, 16'h0, 0},
			'{16'hf02d, 16'h5000, 0, 8'h00, 8'h00, 0, 8'h20, 1, 1, 16'h5006, 0},
			'{16'hf42d, 16'h5000, 0, 8'h00, 8'h00, 0, 8'h20, 1, 0, 16'h0, 0},
			'{16'hf7ed, 16'h5000, 0, 8'h00, 8'h00, 0, 8'h00, 1, 1, 16'h4ffe, 0},
			'{16'h0000, 16'h0010, 0, 8'h00, 8'h00, 0, 8'h00, 0, 0, 16'h0, 0}
		};
		miscompares = 0; cmp_count = 0; rst_b = 1'b0;
		drive(rows[27]);
		instr_valid = 1'b0;
		repeat (4) @(negedge clock);
		chk("ready_rst", 16'h1, {15'h0, ready});
		chk("pc_load_rst", 16'h0, {15'h0, pc_load});
		rst_b = 1'b1;
		foreach (rows[i]) begin
			r = rows[i];
			@(negedge clock);
			drive(r);
			#1;
			chk("rd_index", {11'h0, r.instr[15:12] == 4'h3 ? {1'b1, r.instr[7:4]} : r.instr[8:4]}, {11'h0, rd_index});
			chk("rr_index", {11'h0, r.instr[9], r.instr[3:0]}, {11'h0, rr_index});
			chk("io_sel", {8'h0, r.instr[7:0]}, {8'h0, io_addr, io_bit_index});
			@(negedge clock);
			instr_valid = 1'b0;
			opnd = (r.instr[15:12] == 4'h3) ? {r.instr[11:8], r.instr[3:0]} : r.rr;
			chk("retire", {15'h0, r.ret}, {15'h0, retire});
			chk("pc_load", {15'h0, r.ld}, {15'h0, pc_load});
			chk("flush_fetch", {15'h0, r.ld}, {15'h0, flush_fetch});
			chk("status_we", {15'h0, r.swe}, {15'h0, status_we});
			chk("status_mask", r.swe ? 16'h002f : 16'h0, {8'h0, status_mask});
			if (r.ld) chk("pc_target", r.tgt, pc_target);
			if (r.swe) chk("status_next", {8'h0, exp_flags(r.st, r.rd, opnd, r.instr[12] ? 1'b0 : r.st[0],
				r.instr[12] ? 1'b1 : r.st[1])}, {8'h0, status_next});
			cnt = 0;
			while (ready !== 1'b1 && cnt < 5) begin
				cnt++;
				@(negedge clock);
			end
			chk("hold_cycles", r.ld ? ((r.tgt == r.pc + 16'h3) ? 16'h2 : 16'h1) : 16'h0, cnt[15:0]);
		end
		// Back-to-back compares, one per cycle
		@(negedge clock);
		drive(rows[0]);
		@(negedge clock);
		drive(rows[3]);
		chk("b2b_first", {8'h0, exp_flags(8'hd0, 8'h10, 8'h01, 1'b0, 1'b1)}, {8'h0, status_next});
		@(negedge clock);
		chk("b2b_we", 16'h1, {15'h0, status_we});
		chk("b2b_second", {8'h0, exp_flags(8'h10, 8'h80, 8'hff, 1'b0, 1'b1)}, {8'h0, status_next});
		// Compare offered during the hold after a taken branch is ignored
		drive(rows[12]);
		@(negedge clock);
		drive(rows[0]);
		chk("hold_ready", 16'h0, {15'h0, ready});
		@(negedge clock);
		chk("hold_ignored", 16'h0, {15'h0, status_we});
		@(negedge clock);
		chk("after_hold", 16'h1, {15'h0, status_we});
		// Reset in the middle of a redirect
		drive(rows[6]);
		@(negedge clock);
		instr_valid = 1'b0;
		rst_b = 1'b0;
		#1;
		chk("rst_pc_load", 16'h0, {15'h0, pc_load});
		chk("rst_ready", 16'h1, {15'h0, ready});
		@(negedge clock);
		rst_b = 1'b1;
		@(negedge clock);
		chk("rst_retire", 16'h0, {15'h0, retire});
		drive(rows[0]);
		@(negedge clock);
		instr_valid = 1'b0;
		chk("rst_first_we", 16'h1, {15'h0, status_we});
		wrap_up();
	end
endmodule

`default_nettype wire
